/* core/hpc_consts.vh */
// Constants for the hot-plug control pin block
`ifndef HPC_CONSTS_VH
`define HPC_CONSTS_VH

// ****************************************
// Serial address
// ****************************************
`define HPC_ADDR_HIGH 5'h1D

// ****************************************
// Register indexes
// ****************************************
`define HPC_REG_CTRL 8'h00
`define HPC_REG_STAT 8'h01

// ****************************************
// Control fields
// ****************************************
`define HPC_CTRL_RUN 0
`define HPC_CTRL_NOTIFY_EN 1
`define HPC_CTRL_GPIO_DIR 2
`define HPC_CTRL_GPIO_VAL 3
`define HPC_CTRL_RESET 8'h01

// ****************************************
// Status fields
// ****************************************
`define HPC_STAT_EVENT 0
`define HPC_STAT_SENSE 1
`define HPC_STAT_GPIO 2

`endif

/* core/hpc_control_pins.v */
// Hot-plug notification, control pins and serial port of the display encoder
`timescale 1ns/1ps
`default_nettype none
`include "hpc_consts.vh"
// Behaviour
// - The video qualifier input is high exactly while active pixels arrive and gates pixel acceptance.
// - Line and frame timing of incoming data is taken from the horizontal and vertical sync inputs.
// - With the notify pin enabled as output, a detected termination change pulls it low.
// - The notify pin is only ever pulled low or released, never driven high.
// - Once low, the notify pin stays low until a serial-port write releases it.
// - The serial address is 1,1,1,0,1 then the inverse of the select pin then the select pin level.
// - While the active-low reset pin is low the device is held in power-on reset.
// - The spare pin direction and output value are set, and its level read, over the serial port.
// - While the reset pin is high, device reset follows a run bit in a serial-port register.
// - The serial port has a controller-driven clock and a two-way data line the device also drives.
module hpc_control_pins (
  // Clock and reset
  input wire clk,
  input wire reset,
  input wire reset_in_n,
  output wire device_reset,
  // Video qualification
  input wire active_video_qualifier,
  input wire hsync_in,
  input wire vsync_in,
  output reg pixel_valid,
  output reg line_start,
  output reg frame_start,
  // Hot plug
  input wire plug_sense_in,
  input wire plug_event_out_n_in,
  output wire plug_event_out_n_out,
  output wire plug_event_out_n_oe_n,
  output wire plug_event_out,
  // Spare general-purpose pin
  input wire gpio_in,
  output wire gpio_out,
  output wire gpio_oe_n,
  // Serial port
  input wire addr_select_pin,
  input wire serial_clock_line,
  input wire serial_data_line_in,
  output wire serial_data_line_out,
  output wire serial_data_line_oe_n
);

  localparam ST_IDLE = 3'h0;
  localparam ST_ADDR = 3'h1;
  localparam ST_WREG = 3'h2;
  localparam ST_WDAT = 3'h3;
  localparam ST_ACK = 3'h4;
  localparam ST_RDAT = 3'h5;
  localparam ST_RACK = 3'h6;

  reg [7:0] ctrl;
  reg event_flag;
  reg sense_s1;
  reg sense_s2;
  reg sense_s3;
  reg hsync_q;
  reg vsync_q;
  reg scl_q;
  reg sda_q;
  reg [2:0] state;
  reg [3:0] cnt;
  reg [7:0] shift;
  reg [7:0] tx;
  reg [7:0] idx;
  reg is_read;
  reg drive_low;
  reg stat_clear;
  reg idx_loaded;
  wire core_reset;
  wire [6:0] my_addr;
  wire start_cond;
  wire stop_cond;
  wire scl_rise;
  wire scl_fall;
  wire sense_change;
  reg [7:0] rd_val;

  // ****************************************
  // Reset
  // ****************************************
  assign core_reset = reset | ~reset_in_n | ~ctrl[`HPC_CTRL_RUN];
  assign device_reset = core_reset;

  // ****************************************
  // Video qualification
  // ****************************************
  always @(posedge clk) begin
    if (core_reset) begin
      pixel_valid <= 1'b0;
      line_start <= 1'b0;
      frame_start <= 1'b0;
      // Track the pins in reset: no false edge on release
      hsync_q <= hsync_in;
      vsync_q <= vsync_in;
    end else begin
      pixel_valid <= active_video_qualifier;
      hsync_q <= hsync_in;
      vsync_q <= vsync_in;
      line_start <= hsync_in & ~hsync_q;
      frame_start <= vsync_in & ~vsync_q;
    end
  end

  // ****************************************
  // Hot-plug sense and notification
  // ****************************************
  assign sense_change = sense_s2 ^ sense_s3;

  always @(posedge clk) begin
    if (core_reset) begin
      sense_s1 <= 1'b0;
      sense_s2 <= 1'b0;
      sense_s3 <= 1'b0;
      event_flag <= 1'b0;
    end else begin
      sense_s1 <= plug_sense_in;
      sense_s2 <= sense_s1;
      sense_s3 <= sense_s2;
      // Set wins over a release in the same cycle
      event_flag <= sense_change | (event_flag & ~stat_clear);
    end
  end

  assign plug_event_out = event_flag;
  assign plug_event_out_n_out = 1'b0;
  assign plug_event_out_n_oe_n = ~(event_flag & ctrl[`HPC_CTRL_NOTIFY_EN]);

  // ****************************************
  // Spare pin
  // ****************************************
  assign gpio_out = ctrl[`HPC_CTRL_GPIO_VAL];
  assign gpio_oe_n = ~ctrl[`HPC_CTRL_GPIO_DIR];

  // ****************************************
  // Serial port
  // ****************************************
  assign my_addr = {`HPC_ADDR_HIGH, ~addr_select_pin, addr_select_pin};
  assign start_cond = serial_clock_line & scl_q & sda_q & ~serial_data_line_in;
  assign stop_cond = serial_clock_line & scl_q & ~sda_q & serial_data_line_in;
  assign scl_rise = serial_clock_line & ~scl_q;
  assign scl_fall = ~serial_clock_line & scl_q;
  assign serial_data_line_out = 1'b0;
  assign serial_data_line_oe_n = ~drive_low;

  always @* begin
    rd_val = 8'h00;
    case (idx)
      `HPC_REG_CTRL: rd_val = ctrl;
      `HPC_REG_STAT: rd_val = {5'h00, gpio_in, sense_s2, event_flag};
      default: rd_val = 8'h00;
    endcase
  end

  always @(posedge clk) begin
    if (reset | ~reset_in_n) begin
      ctrl <= `HPC_CTRL_RESET;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      state <= ST_IDLE;
      cnt <= 4'h0;
      shift <= 8'h00;
      tx <= 8'h00;
      idx <= 8'h00;
      is_read <= 1'b0;
      drive_low <= 1'b0;
      stat_clear <= 1'b0;
      idx_loaded <= 1'b0;
    end else begin
      scl_q <= serial_clock_line;
      sda_q <= serial_data_line_in;
      stat_clear <= 1'b0;
      if (start_cond) begin
        state <= ST_ADDR;
        cnt <= 4'h0;
        idx_loaded <= 1'b0;
        drive_low <= 1'b0;
      end else if (stop_cond) begin
        state <= ST_IDLE;
        drive_low <= 1'b0;
      end else if (scl_rise) begin
        case (state)
          ST_ADDR, ST_WREG, ST_WDAT: begin
            shift <= {shift[6:0], serial_data_line_in};
            cnt <= cnt + 4'h1;
          end
          ST_RDAT: begin
            tx <= {tx[6:0], 1'b0};
            cnt <= cnt + 4'h1;
          end
          ST_RACK: begin
            if (serial_data_line_in) begin
              state <= ST_IDLE;
            end else begin
              idx <= idx + 8'h01;
            end
          end
          default: begin
          end
        endcase
      end else if (scl_fall) begin
        case (state)
          ST_ADDR: begin
            if (cnt == 4'h8) begin
              if (shift[7:1] == my_addr) begin
                is_read <= shift[0];
                drive_low <= 1'b1;
                state <= ST_ACK;
              end else begin
                state <= ST_IDLE;
              end
            end
          end
          ST_WREG: begin
            if (cnt == 4'h8) begin
              idx <= shift;
              idx_loaded <= 1'b1;
              drive_low <= 1'b1;
              state <= ST_ACK;
            end
          end
          ST_WDAT: begin
            if (cnt == 4'h8) begin
              if (idx == `HPC_REG_CTRL) begin
                ctrl <= shift;
              end
              if (idx == `HPC_REG_STAT) begin
                stat_clear <= shift[`HPC_STAT_EVENT];
              end
              idx <= idx + 8'h01;
              drive_low <= 1'b1;
              state <= ST_ACK;
            end
          end
          ST_ACK: begin
            cnt <= 4'h0;
            if (is_read) begin
              tx <= rd_val;
              drive_low <= ~rd_val[7];
              state <= ST_RDAT;
            end else begin
              drive_low <= 1'b0;
              state <= idx_loaded ? ST_WDAT : ST_WREG;
            end
          end
          ST_RDAT: begin
            if (cnt == 4'h8) begin
              drive_low <= 1'b0;
              state <= ST_RACK;
            end else begin
              drive_low <= ~tx[7];
            end
          end
          ST_RACK: begin
            tx <= rd_val;
            drive_low <= ~rd_val[7];
            cnt <= 4'h0;
            state <= ST_RDAT;
          end
          default: begin
          end
        endcase
      end
    end
  end

endmodule // hpc_control_pins
`default_nettype wire

/* tb/hpc_control_pins_assertions.sv */
// Assertions on the hot-plug control pin ports
`timescale 1ns/1ps
`default_nettype none
module hpc_control_pins_assertions (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  input wire logic reset_in_n,
  input wire logic device_reset,
  // Video
  input wire logic active_video_qualifier,
  input wire logic hsync_in,
  input wire logic vsync_in,
  input wire logic pixel_valid,
  input wire logic line_start,
  input wire logic frame_start,
  // Hot plug and serial
  input wire logic plug_sense_in,
  input wire logic plug_event_out_n_out,
  input wire logic plug_event_out_n_oe_n,
  input wire logic plug_event_out,
  input wire logic serial_clock_line,
  input wire logic serial_data_line_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  a_pixel_follow: assert property (!device_reset |=> pixel_valid == $past(active_video_qualifier) || device_reset)
    else $error("pixel_valid lost the qualifier");
  a_line_pulse: assert property (!device_reset && !$past(device_reset) && $rose(hsync_in) |=> line_start || device_reset)
    else $error("line_start missing");
  a_frame_cause: assert property (frame_start |-> $past(vsync_in) && !$past(vsync_in, 2))
    else $error("frame_start without vsync rise");
  a_drain_open: assert property (!plug_event_out_n_out)
    else $error("notify pin driven high");
  a_notify_cause: assert property (!plug_event_out_n_oe_n |-> plug_event_out)
    else $error("notify pin low without event");
  a_event_hold: assert property (plug_event_out && serial_clock_line && $past(serial_clock_line) |=> plug_event_out || device_reset)
    else $error("event dropped on its own");
  a_pin_reset: assert property (!reset_in_n |-> device_reset)
    else $error("reset pin ignored");
  a_reset_clear: assert property (!reset_in_n |=> plug_event_out_n_oe_n && !plug_event_out && !pixel_valid)
    else $error("state kept in reset");
  a_sense_event: assert property ($changed(plug_sense_in) && !device_reset |-> ##[1:4] (plug_event_out || device_reset))
    else $error("sense change not flagged");
  a_sda_open: assert property (!serial_data_line_out)
    else $error("data line driven high");
endmodule // hpc_control_pins_assertions
`default_nettype wire

/* tb/hpc_far_end.sv */
// Far-side model: pulled-up pins, open-drain except the spare pin, which is driven to either level
`timescale 1ns/1ps
`default_nettype none
module hpc_far_end (
  // Pin enables and driven levels
  input wire logic evt_oe_n,
  input wire logic gpio_oe_n,
  input wire logic gpio_out,
  input wire logic sda_oe_n,
  input wire logic sda_host,
  // Resolved levels
  output logic evt_pin,
  output logic gpio_pin,
  output logic sda_pin
);
  assign evt_pin = evt_oe_n;
  assign gpio_pin = gpio_oe_n | gpio_out;
  assign sda_pin = sda_oe_n & sda_host;
endmodule // hpc_far_end
`default_nettype wire

/* tb/hpc_control_pins_bench.sv */
// Self-checking bench of the hot-plug control pins
`timescale 1ns/1ps
`default_nettype none
module hpc_control_pins_bench;
  logic clk = 0, reset = 1, rn = 1, avq = 0, hs = 0, vs = 0, sense = 0, asp = 1, scl = 1, sdm = 1, ep;
  wire drst, pv, ls, fs, eo, eoe, ev, go, goe, so, soe, epin, gpin, sda;
  integer fail_count = 0, samples_checked = 0, seed = 78070, k, rv;
  logic hs_prev = 0, vs_prev = 0, exp_ls, exp_fs;
  logic [8:0] r;
  logic [7:0] d;
  always #50 clk = ~clk;
  hpc_control_pins uut (.clk(clk), .reset(reset), .reset_in_n(rn), .device_reset(drst),
    .active_video_qualifier(avq), .hsync_in(hs), .vsync_in(vs), .pixel_valid(pv), .line_start(ls),
    .frame_start(fs), .plug_sense_in(sense), .plug_event_out_n_in(epin), .plug_event_out_n_out(eo),
    .plug_event_out_n_oe_n(eoe), .plug_event_out(ev), .gpio_in(gpin), .gpio_out(go), .gpio_oe_n(goe),
    .addr_select_pin(asp), .serial_clock_line(scl), .serial_data_line_in(sda),
    .serial_data_line_out(so), .serial_data_line_oe_n(soe));
  hpc_far_end far (.evt_oe_n(eoe), .gpio_oe_n(goe), .gpio_out(go), .sda_oe_n(soe), .sda_host(sdm),
    .evt_pin(epin), .gpio_pin(gpin), .sda_pin(sda));
  task chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task half; repeat (3) @(negedge clk); endtask
  task bits(input logic [8:0] b);
    for (int i = 8; i >= 0; i--) begin
      sdm = b[i]; half; scl = 1; half; r[i] = sda; scl = 0;
    end
  endtask
  task start; sdm = 1; half; scl = 1; half; sdm = 0; half; scl = 0; endtask
  task stop; sdm = 0; half; scl = 1; half; sdm = 1; half; endtask
  task wr(input logic [7:0] idx, input logic [7:0] v);
    start; bits({5'h1D, ~asp, asp, 2'h1}); chk(r[0], 8'h00);
    bits({idx, 1'h1}); chk(r[0], 8'h00); bits({v, 1'h1}); chk(r[0], 8'h00); stop;
  endtask
  task rd(input logic [7:0] idx);
    start; bits({5'h1D, ~asp, asp, 2'h1}); bits({idx, 1'h1}); stop;
    start; bits({5'h1D, ~asp, asp, 2'h3}); chk(r[0], 8'h00); bits(9'h1FF); d = r[8:1]; stop;
  endtask
  task wrap_up;
    $display("checks=%0d errors=%0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task wait_evt;
    for (k = 0; k < 10 && eoe !== 1'h0; k++) @(negedge clk);
    if (eoe !== 1'h0) begin
      fail_count++;
      wrap_up;
    end
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    wrap_up;
  end
  initial begin
    repeat (3) @(negedge clk);
    reset = 0;
    chk(eoe, 8'h01);
    repeat (200) begin
      ep = avq;
      exp_ls = hs & ~hs_prev;
      exp_fs = vs & ~vs_prev;
      hs_prev = hs;
      vs_prev = vs;
      @(negedge clk);
      chk(pv, ep);
      chk(ls, exp_ls);
      chk(fs, exp_fs);
      rv = $random(seed);
      avq = rv[0];
      hs = rv[1];
      vs = rv[2];
    end
    wr(8'h00, 8'h03);
    sense = 1; wait_evt; chk(eoe, 8'h00);
    sense = 0; repeat (20) @(negedge clk); chk(epin, 8'h00);
    rd(8'h01); chk(d, {5'h00, 1'h1, sense, 1'h1});
    wr(8'h01, 8'h01); chk(epin, 8'h01);
    wr(8'h00, 8'h05); chk(gpin, 8'h00);
    chk(goe, 8'h00);
    chk(go, 8'h00);
    rd(8'h01); chk(d, 8'h00);
    wr(8'h00, 8'h00); chk(drst, 8'h01);
    wr(8'h00, 8'h03); chk(drst, 8'h00);
    asp = 0;
    start;
    bits({5'h1D, ~asp, asp, 2'h1});
    bits(9'h001);
    stop;
    start;
    bits({5'h1D, ~asp, asp, 2'h3});
    chk(r[0], 8'h00);
    bits(9'h1FE);
    chk(r[8:1], 8'h03);
    bits(9'h1FF);
    chk(r[8:1], 8'h04);
    stop;
    start;
    bits({5'h1D, asp, ~asp, 2'h1});
    chk(r[0], 8'h01);
    stop;
    sense = 1; wait_evt; chk(eoe, 8'h00);
    rn = 0; @(negedge clk); @(negedge clk); chk({drst, eoe, ev}, 8'h06);
    rn = 1; @(negedge clk); chk(drst, 8'h00);
    chk({eo, so}, 8'h00);
    wrap_up;
  end
endmodule // hpc_control_pins_bench
bind hpc_control_pins hpc_control_pins_assertions chk_i (.clk(clk), .reset(reset), .reset_in_n(reset_in_n),
  .device_reset(device_reset), .active_video_qualifier(active_video_qualifier), .hsync_in(hsync_in),
  .vsync_in(vsync_in), .pixel_valid(pixel_valid), .line_start(line_start), .frame_start(frame_start),
  .plug_sense_in(plug_sense_in), .plug_event_out_n_out(plug_event_out_n_out),
  .plug_event_out_n_oe_n(plug_event_out_n_oe_n), .plug_event_out(plug_event_out),
  .serial_clock_line(serial_clock_line), .serial_data_line_out(serial_data_line_out));
`default_nettype wire
